// >>> src/ccts_consts.vh
// Constants for the calendar cam time switch block.
// Assumes inclusion by the switch modules; definitions only.
// Operation
// - A weekly switch has three slots, each with its own days and times, driving one output.
// - A selected day reaching a slot's on time sets the output to one.
// - A selected day reaching a slot's off time clears the output; otherwise it holds.
// - Opposite actions in the same minute resolve to the highest-numbered slot.
// - Each slot has a seven-bit day mask, Monday in bit 0 to Sunday in bit 6.
// - Times are hour and minute, 00:00 to 23:59; out-of-range values are rejected.
// - A time set to the empty marker performs no switching for that edge.
// - The yearly switch sets its output on reaching the on date and holds it.
// - The yearly switch clears its output on reaching the off date.
// - Dates are a month field then a day field, compared month first.
`ifndef CCTS_CONSTS_VH
`define CCTS_CONSTS_VH
`define CCTS_NUM_SLOTS 3
`define CCTS_DAY_W 7
`define CCTS_HOUR_W 5
`define CCTS_MIN_W 6
`define CCTS_MONTH_W 4
`define CCTS_MDAY_W 5
`define CCTS_HOUR_MAX 5'h17
`define CCTS_MIN_MAX 6'h3B
`define CCTS_MONTH_MIN 4'h1
`define CCTS_MONTH_MAX 4'hC
`define CCTS_MDAY_MIN 5'h01
`define CCTS_MDAY_MAX 5'h1F
`endif

// >>> src/ccts_slot_match.v
// One weekly schedule slot: decodes its on and off events for the current minute.
// Assumes calendar fields are stable while min_tick is high.
`timescale 1ns/1ps
`include "ccts_consts.vh"
module ccts_slot_match (
  input wire [`CCTS_DAY_W-1:0] day_mask,
  input wire on_empty,
  input wire [`CCTS_HOUR_W-1:0] on_hour,
  input wire [`CCTS_MIN_W-1:0] on_min,
  input wire off_empty,
  input wire [`CCTS_HOUR_W-1:0] off_hour,
  input wire [`CCTS_MIN_W-1:0] off_min,
  input wire [`CCTS_DAY_W-1:0] day_onehot,
  input wire [`CCTS_HOUR_W-1:0] cur_hour,
  input wire [`CCTS_MIN_W-1:0] cur_min,
  output wire on_hit,
  output wire off_hit
);
  // ----------------------------------------
  // Time validity and compare
  // ----------------------------------------
  function time_ok;
    input [`CCTS_HOUR_W-1:0] h;
    input [`CCTS_MIN_W-1:0] m;
    begin
      time_ok = (h <= `CCTS_HOUR_MAX) && (m <= `CCTS_MIN_MAX);
    end
  endfunction

  wire day_sel;
  assign day_sel = |(day_mask & day_onehot);
  // Empty marker or invalid time never fires
  assign on_hit = day_sel && !on_empty && time_ok(on_hour, on_min) &&
                  (on_hour == cur_hour) && (on_min == cur_min);
  assign off_hit = day_sel && !off_empty && time_ok(off_hour, off_min) &&
                   (off_hour == cur_hour) && (off_min == cur_min);
endmodule

// >>> src/ccts_top.v
// Weekly three-slot and yearly date time switches sharing one calendar.
// Assumes calendar fields come from logic on ref_clk and min_tick pulses
// one cycle at each new minute, with fields already showing that minute.
`timescale 1ns/1ps
`include "ccts_consts.vh"
module ccts_top (
  input wire ref_clk,
  input wire arst_n,
  input wire min_tick,
  input wire [`CCTS_DAY_W-1:0] cur_day_onehot,
  input wire [`CCTS_HOUR_W-1:0] cur_hour,
  input wire [`CCTS_MIN_W-1:0] cur_min,
  input wire [`CCTS_MONTH_W-1:0] cur_month,
  input wire [`CCTS_MDAY_W-1:0] cur_mday,
  input wire [`CCTS_NUM_SLOTS*`CCTS_DAY_W-1:0] slot_day_mask,
  input wire [`CCTS_NUM_SLOTS-1:0] slot_on_empty,
  input wire [`CCTS_NUM_SLOTS*`CCTS_HOUR_W-1:0] slot_on_hour,
  input wire [`CCTS_NUM_SLOTS*`CCTS_MIN_W-1:0] slot_on_min,
  input wire [`CCTS_NUM_SLOTS-1:0] slot_off_empty,
  input wire [`CCTS_NUM_SLOTS*`CCTS_HOUR_W-1:0] slot_off_hour,
  input wire [`CCTS_NUM_SLOTS*`CCTS_MIN_W-1:0] slot_off_min,
  input wire [`CCTS_MONTH_W-1:0] year_on_month,
  input wire [`CCTS_MDAY_W-1:0] year_on_mday,
  input wire [`CCTS_MONTH_W-1:0] year_off_month,
  input wire [`CCTS_MDAY_W-1:0] year_off_mday,
  output reg weekly_out_q,
  output reg yearly_out_q
);
  // ----------------------------------------
  // Weekly slots
  // ----------------------------------------
  wire [`CCTS_NUM_SLOTS-1:0] on_hit;
  wire [`CCTS_NUM_SLOTS-1:0] off_hit;
  genvar g;
  generate
    for (g = 0; g < `CCTS_NUM_SLOTS; g = g + 1) begin : g_slot
      ccts_slot_match u_slot (
        .day_mask(slot_day_mask[g*`CCTS_DAY_W +: `CCTS_DAY_W]),
        .on_empty(slot_on_empty[g]),
        .on_hour(slot_on_hour[g*`CCTS_HOUR_W +: `CCTS_HOUR_W]),
        .on_min(slot_on_min[g*`CCTS_MIN_W +: `CCTS_MIN_W]),
        .off_empty(slot_off_empty[g]),
        .off_hour(slot_off_hour[g*`CCTS_HOUR_W +: `CCTS_HOUR_W]),
        .off_min(slot_off_min[g*`CCTS_MIN_W +: `CCTS_MIN_W]),
        .day_onehot(cur_day_onehot),
        .cur_hour(cur_hour),
        .cur_min(cur_min),
        .on_hit(on_hit[g]),
        .off_hit(off_hit[g])
      );
    end
  endgenerate

  // Highest slot with any action wins; within a slot, off beats on
  // so a slot with equal on and off times stays safely off.
  reg weekly_d;
  integer i;
  always @* begin
    weekly_d = weekly_out_q;
    for (i = 0; i < `CCTS_NUM_SLOTS; i = i + 1) begin
      if (on_hit[i]) begin
        weekly_d = 1'b1;
      end
      if (off_hit[i]) begin
        weekly_d = 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Yearly date switch
  // ----------------------------------------
  function date_ok;
    input [`CCTS_MONTH_W-1:0] mo;
    input [`CCTS_MDAY_W-1:0] dy;
    begin
      date_ok = (mo >= `CCTS_MONTH_MIN) && (mo <= `CCTS_MONTH_MAX) &&
                (dy >= `CCTS_MDAY_MIN) && (dy <= `CCTS_MDAY_MAX);
    end
  endfunction

  // Date events only at midnight so each date fires once per year
  wire midnight;
  assign midnight = (cur_hour == {`CCTS_HOUR_W{1'b0}}) && (cur_min == {`CCTS_MIN_W{1'b0}});
  wire y_on_hit;
  wire y_off_hit;
  assign y_on_hit = midnight && date_ok(year_on_month, year_on_mday) &&
                    (cur_month == year_on_month) && (cur_mday == year_on_mday);
  assign y_off_hit = midnight && date_ok(year_off_month, year_off_mday) &&
                     (cur_month == year_off_month) && (cur_mday == year_off_mday);

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      weekly_out_q <= 1'b0;
      yearly_out_q <= 1'b0;
    end else if (min_tick) begin
      weekly_out_q <= weekly_d;
      if (y_off_hit) begin
        yearly_out_q <= 1'b0;
      end else if (y_on_hit) begin
        yearly_out_q <= 1'b1;
      end
    end
  end
endmodule

// >>> test/ccts_cal_model.sv
// Calendar source model: time fields plus a one-cycle minute tick.
// Assumes requests are set by nonblocking assignment at the falling edge.
`timescale 1ns/1ps
module ccts_cal_model (
  input wire ref_clk,
  input wire go,
  input wire [26:0] req,
  output reg min_tick = 1'b0,
  output reg [26:0] cal = 27'h000_0000
);
  always @(negedge ref_clk) begin
    min_tick <= go;
    if (go) begin
      cal <= req;
    end
  end
endmodule

// >>> test/ccts_top_asserts.sv
// Checker for ccts_top output timing.
// Assumes it is bound to ccts_top and sees its ports only.
`timescale 1ns/1ps
`include "ccts_consts.vh"
module ccts_chk (
  input wire ref_clk,
  input wire arst_n,
  input wire min_tick,
  input wire [`CCTS_HOUR_W-1:0] cur_hour,
  input wire [`CCTS_MIN_W-1:0] cur_min,
  input wire [`CCTS_MONTH_W-1:0] cur_month,
  input wire weekly_out_q,
  input wire yearly_out_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence no_tick2; !min_tick ##1 !min_tick; endsequence
  wk_hold_a: assert property (!min_tick |=> $stable(weekly_out_q))
    else $error("weekly moved");
  yr_hold_a: assert property (no_tick2 |=> $stable(yearly_out_q))
    else $error("yearly moved");
  yr_midnt_a: assert property (min_tick && (cur_hour != 0 || cur_min != 0) |=> $stable(yearly_out_q))
    else $error("yearly off midnight");
  hr_range_a: assert property (min_tick && cur_hour > 23 |=> $stable(weekly_out_q))
    else $error("bad hour fired");
  mn_range_a: assert property (min_tick && cur_min > 59 |=> $stable(weekly_out_q))
    else $error("bad minute fired");
  mo_range_a: assert property (min_tick && (cur_month == 0 || cur_month > 12) |=> $stable(yearly_out_q))
    else $error("bad month fired");
  wk_cause_a: assert property ($changed(weekly_out_q) |-> $past(min_tick))
    else $error("weekly without tick");
  yr_cause_a: assert property ($changed(yearly_out_q) |-> $past(min_tick) && $past(cur_hour) == 0)
    else $error("yearly without midnight tick");
endmodule
bind ccts_top ccts_chk i_ccts_chk (.*);

// >>> test/ccts_top_test.sv
// Self-checking bench for weekly and yearly switching of ccts_top.
// Assumes ccts_cal_model feeds the calendar; one check per minute tick.
`timescale 1ns/1ps
module ccts_top_test;
  reg ref_clk = 1'b0;
  reg arst_n = 1'b0;
  reg go = 1'b0;
  reg [26:0] req = 27'h000_0000;
  reg [20:0] mask = {7'h60, 7'h02, 7'h7F};
  reg [2:0] on_e = 3'h0;
  reg [2:0] off_e = 3'h0;
  reg [14:0] on_h = {5'h10, 5'h03, 5'h06};
  reg [17:0] on_m = {6'h1E, 6'h0A, 6'h1E};
  wire min_tick;
  wire [26:0] cal;
  wire wk;
  wire yr;
  integer num_errors = 0;
  integer checked = 0;
  always #4 ref_clk = ~ref_clk;
  ccts_cal_model i_ccts_cal_model (.ref_clk(ref_clk), .go(go), .req(req), .min_tick(min_tick),
    .cal(cal));
  ccts_top i_ccts_top (.ref_clk(ref_clk), .arst_n(arst_n), .min_tick(min_tick),
    .cur_day_onehot(cal[26:20]), .cur_hour(cal[19:15]), .cur_min(cal[14:9]),
    .cur_month(cal[8:5]), .cur_mday(cal[4:0]), .slot_day_mask(mask), .slot_on_empty(on_e),
    .slot_on_hour(on_h), .slot_on_min(on_m), .slot_off_empty(off_e),
    .slot_off_hour({5'h17, 5'h04, 5'h08}), .slot_off_min({6'h0A, 6'h0F, 6'h00}),
    .year_on_month(4'h3), .year_on_mday(5'h01), .year_off_month(4'h4), .year_off_mday(5'h04),
    .weekly_out_q(wk), .yearly_out_q(yr));
  task chk(input [1:0] got, input [1:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One tick, then outputs judged one cycle later
  task tk(input [26:0] r, input [1:0] exp);
    @(negedge ref_clk);
    go <= 1'b1;
    req <= r;
    @(negedge ref_clk);
    go <= 1'b0;
    @(negedge ref_clk);
    chk({wk, yr}, exp);
  endtask
  task s_weekly;
    tk({7'h02, 5'h03, 6'h0A, 4'h1, 5'h05}, 2'h2);
    tk({7'h02, 5'h04, 6'h0F, 4'h1, 5'h05}, 2'h0);
    tk({7'h04, 5'h03, 6'h0A, 4'h1, 5'h05}, 2'h0);
    tk({7'h01, 5'h06, 6'h1E, 4'h1, 5'h05}, 2'h2);
    tk({7'h01, 5'h07, 6'h00, 4'h1, 5'h05}, 2'h2);
  endtask
  task s_prio;
    mask[20:14] = 7'h7F;
    on_h[14:10] = 5'h08;
    on_m[17:12] = 6'h00;
    tk({7'h01, 5'h08, 6'h00, 4'h1, 5'h05}, 2'h2);
    on_e = 3'h4;
    tk({7'h01, 5'h08, 6'h00, 4'h1, 5'h05}, 2'h0);
  endtask
  task s_range;
    tk({7'h01, 5'h18, 6'h3C, 4'h0, 5'h00}, 2'h0);
    // Slot 0 on time set to 24:30 must be refused even when the clock shows it
    on_h[4:0] = 5'h18;
    tk({7'h01, 5'h18, 6'h1E, 4'h1, 5'h05}, 2'h0);
    on_h[4:0] = 5'h06;
    tk({7'h01, 5'h06, 6'h1E, 4'h1, 5'h05}, 2'h2);
    off_e = 3'h1;
    tk({7'h01, 5'h08, 6'h00, 4'h1, 5'h05}, 2'h2);
  endtask
  task s_yearly;
    tk({7'h01, 5'h0C, 6'h00, 4'h3, 5'h01}, 2'h2);
    tk({7'h01, 5'h00, 6'h00, 4'h1, 5'h01}, 2'h2);
    tk({7'h01, 5'h00, 6'h00, 4'h3, 5'h01}, 2'h3);
    tk({7'h02, 5'h00, 6'h00, 4'h3, 5'h02}, 2'h3);
    tk({7'h01, 5'h00, 6'h00, 4'h4, 5'h04}, 2'h2);
  endtask
  task final_report;
    $display("errors=%0d checked=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge ref_clk);
    arst_n = 1'b1;
    s_weekly;
    s_prio;
    s_range;
    s_yearly;
    final_report;
  end
endmodule
